// [hw/pcg_top.sv]
`timescale 1ns/1ps
// How it works
// - Trigger write captures winner ID and priority together
// - Trigger accepts any write, reads zero, stores nothing
// - Claimed priority holds captured winner priority or a software write, resets zero
// - Claimed priority access direct or inverted by order
// - Interrupt only above both nesting and global thresholds
// - Current priority is software-written four-bit field only
// - Current priority access direct or inverted by order
// - Gateway config per configurable source at 0x4000+4S
// - Config bit one selects level or edge trigger
// - Config bit zero selects polarity, resets zero
// - Winner ID in pointer bits 9:2, lowest ID ties
// - Threshold masks priorities at or below it
module pcg_top #(
  parameter int                        NUM_SRC     = 255,
  parameter logic [pcg_pkg::MAX_SRC:0] GW_CFG_MASK = '1
) (
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_rst,
  input  wire logic [NUM_SRC:1]                i_src_irq,
  input  wire logic [NUM_SRC*4-1:0]            i_src_prio,
  input  wire logic [NUM_SRC:1]                i_src_en,
  input  wire logic [pcg_pkg::PRIO_W-1:0]      i_glb_thresh,
  input  wire logic                            i_prio_reverse,
  input  wire logic [pcg_pkg::BASE_W-1:0]      i_vec_base,
  input  wire logic [NUM_SRC:1]                i_gw_clr,
  input  wire logic                            i_csr_wr,
  input  wire logic                            i_csr_rd,
  input  wire logic [pcg_pkg::CSR_ADDR_W-1:0]  i_csr_addr,
  input  wire logic [pcg_pkg::DATA_W-1:0]      i_csr_wdata,
  output logic      [pcg_pkg::DATA_W-1:0]      o_csr_rdata,
  output logic                                 o_csr_rvalid,
  input  wire logic                            i_mm_wr,
  input  wire logic                            i_mm_rd,
  input  wire logic [pcg_pkg::MM_ADDR_W-1:0]   i_mm_addr,
  input  wire logic [pcg_pkg::DATA_W-1:0]      i_mm_wdata,
  output logic      [pcg_pkg::DATA_W-1:0]      o_mm_rdata,
  output logic                                 o_mm_rvalid,
  output logic                                 o_ext_irq,
  output logic      [pcg_pkg::ID_W-1:0]        o_claim_id,
  output logic      [pcg_pkg::PRIO_W-1:0]      o_claim_prio,
  output logic      [NUM_SRC:1]                o_gw_pending
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (NUM_SRC < 1 || NUM_SRC > pcg_pkg::MAX_SRC) begin : g_bad_num
    $error("NUM_SRC must lie in 1..255");
  end

  if ($clog2(NUM_SRC + 1) > pcg_pkg::ID_W) begin : g_bad_id
    $error("NUM_SRC does not fit the claim ID field");
  end

  // ---------------------------------------------------------------
  // Local decode
  // ---------------------------------------------------------------
  function automatic logic csr_hit(input logic                            stb,
                                   input logic [pcg_pkg::CSR_ADDR_W-1:0] addr,
                                   input logic [pcg_pkg::CSR_ADDR_W-1:0] reg_addr);
    return stb && (addr == reg_addr);
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [NUM_SRC:1]               sync1_r;
  logic [NUM_SRC:1]               sync2_r;
  logic [NUM_SRC:1]               lvl_prev_r;
  logic [NUM_SRC:1]               sync1_nxt;
  logic [NUM_SRC:1]               sync2_nxt;
  logic [NUM_SRC:1]               lvl_prev_nxt;
  logic [NUM_SRC:1]               lvl;
  logic [NUM_SRC:1]               edge_set;
  logic [NUM_SRC:1]               latch_r;
  logic [NUM_SRC:1]               latch_nxt;
  logic [NUM_SRC:1]               gw_type;
  logic [NUM_SRC:1]               gw_pol;
  logic [NUM_SRC:1]               gw_req;
  logic [NUM_SRC:1]               cand;
  logic [pcg_pkg::PRIO_W-1:0]     eff_prio [NUM_SRC:1];
  logic                           win_found;
  logic [pcg_pkg::ID_W-1:0]       win_id;
  logic [pcg_pkg::PRIO_W-1:0]     win_prio;
  logic [pcg_pkg::PRIO_W-1:0]     glb_int;
  logic                           cap_fire;
  logic                           claim_wr;
  logic                           cur_wr;
  logic [pcg_pkg::PRIO_W-1:0]     wr_prio;
  logic                           above_cur;
  logic                           above_glb;
  logic [pcg_pkg::PRIO_W-1:0]     claim_view_r;
  logic [pcg_pkg::PRIO_W-1:0]     claim_view_nxt;
  logic [pcg_pkg::DATA_W-1:0]     ptr_word;
  logic [pcg_pkg::ID_W-1:0]       claim_id_r;
  logic [pcg_pkg::ID_W-1:0]       claim_id_nxt;
  logic [pcg_pkg::PRIO_W-1:0]     claim_prio_r;
  logic [pcg_pkg::PRIO_W-1:0]     claim_prio_nxt;
  logic [pcg_pkg::PRIO_W-1:0]     cur_prio_r;
  logic [pcg_pkg::PRIO_W-1:0]     cur_prio_nxt;
  logic                           irq_r;
  logic                           irq_nxt;
  logic [pcg_pkg::DATA_W-1:0]     csr_rdata_r;
  logic [pcg_pkg::DATA_W-1:0]     csr_rdata_nxt;
  logic                           csr_rvalid_r;
  logic                           mm_rvalid_r;
  logic [pcg_pkg::GW_CFG_W-1:0]   gw_rdata;

  // ---------------------------------------------------------------
  // Gateway configuration storage
  // ---------------------------------------------------------------
  pcg_gw_cfg_mem #(
    .NUM_SRC     (NUM_SRC),
    .GW_CFG_MASK (GW_CFG_MASK)
  ) u_cfg (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_wr      (i_mm_wr),
    .i_rd      (i_mm_rd),
    .i_addr    (i_mm_addr),
    .i_wdata   (i_mm_wdata[pcg_pkg::GW_CFG_W-1:0]),
    .o_rdata   (gw_rdata),
    .o_type    (gw_type),
    .o_pol     (gw_pol)
  );

  // ---------------------------------------------------------------
  // Source synchronisers and gateways
  // ---------------------------------------------------------------
  assign lvl      = sync2_r ^ gw_pol;
  assign edge_set = lvl & ~lvl_prev_r & gw_type;

  always_comb begin
    // Two flops before any gateway logic
    sync1_nxt    = i_src_irq;
    sync2_nxt    = sync1_r;
    lvl_prev_nxt = lvl;
    // Set beats clear; latch unused in level mode
    latch_nxt    = (edge_set | (latch_r & ~i_gw_clr)) & gw_type;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      lvl_prev_r <= '0;
      latch_r    <= '0;
    end else begin
      sync1_r    <= sync1_nxt;
      sync2_r    <= sync2_nxt;
      lvl_prev_r <= lvl_prev_nxt;
      latch_r    <= latch_nxt;
    end
  end

  for (genvar s = 1; s <= NUM_SRC; s++) begin : g_src
    assign gw_req[s]   = (gw_type[s] == pcg_pkg::PCG_EDGE) ? latch_r[s] : lvl[s];
    assign cand[s]     = gw_req[s] & i_src_en[s];
    assign eff_prio[s] = pcg_pkg::prio_map(i_src_prio[(s-1)*4 +: 4], i_prio_reverse);
  end

  assign o_gw_pending = gw_req;

  // ---------------------------------------------------------------
  // Arbiter
  // ---------------------------------------------------------------
  always_comb begin
    win_found = 1'b0;
    win_id    = pcg_pkg::ID_RST;
    win_prio  = pcg_pkg::PRIO_RST;
    for (int s = 1; s <= NUM_SRC; s++) begin
      // Strict compare keeps the lowest ID on a tie
      if (cand[s] && (!win_found || eff_prio[s] > win_prio)) begin
        win_found = 1'b1;
        win_id    = 8'(s);
        win_prio  = eff_prio[s];
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture and priority registers
  // ---------------------------------------------------------------
  assign cap_fire = csr_hit(i_csr_wr, i_csr_addr, pcg_pkg::CSR_CAPTURE_TRIG);
  assign claim_wr = csr_hit(i_csr_wr, i_csr_addr, pcg_pkg::CSR_CLAIM_PRIO);
  assign cur_wr   = csr_hit(i_csr_wr, i_csr_addr, pcg_pkg::CSR_CUR_PRIO);
  assign wr_prio  = i_csr_wdata[pcg_pkg::PRIO_W-1:0];

  always_comb begin
    claim_id_nxt   = claim_id_r;
    claim_prio_nxt = claim_prio_r;
    cur_prio_nxt   = cur_prio_r;
    // Trigger stores nothing, only fires
    if (cap_fire) begin
      claim_id_nxt   = win_id;
      claim_prio_nxt = win_prio;
    end
    if (claim_wr) begin
      claim_prio_nxt = pcg_pkg::prio_map(wr_prio, i_prio_reverse);
    end
    // Only software moves the nesting level
    if (cur_wr) begin
      cur_prio_nxt = pcg_pkg::prio_map(wr_prio, i_prio_reverse);
    end
    claim_view_nxt = pcg_pkg::prio_map(claim_prio_nxt, i_prio_reverse);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      claim_id_r   <= pcg_pkg::ID_RST;
      claim_prio_r <= pcg_pkg::PRIO_RST;
      cur_prio_r   <= pcg_pkg::PRIO_RST;
      claim_view_r <= pcg_pkg::prio_map(pcg_pkg::PRIO_RST, i_prio_reverse);
    end else begin
      claim_id_r   <= claim_id_nxt;
      claim_prio_r <= claim_prio_nxt;
      cur_prio_r   <= cur_prio_nxt;
      claim_view_r <= claim_view_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt request to the core
  // ---------------------------------------------------------------
  assign glb_int   = pcg_pkg::prio_map(i_glb_thresh, i_prio_reverse);
  assign above_cur = win_prio > cur_prio_r;
  assign above_glb = win_prio > glb_int;

  always_comb begin
    // Internal order: higher value wins, threshold masks at or below
    irq_nxt = win_found && above_cur && above_glb;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ---------------------------------------------------------------
  // CSR read path
  // ---------------------------------------------------------------
  // Base is shown, not stored
  assign ptr_word[pcg_pkg::DATA_W-1:pcg_pkg::PTR_BASE_LSB]     = i_vec_base;
  assign ptr_word[pcg_pkg::PTR_BASE_LSB-1:pcg_pkg::PTR_ID_LSB] = claim_id_r;
  assign ptr_word[pcg_pkg::PTR_ID_LSB-1:0]                     = 2'h0;

  always_comb begin
    // One cycle read latency
    csr_rdata_nxt = '0;
    if (i_csr_rd) begin
      case (i_csr_addr)
        pcg_pkg::CSR_CAPTURE_TRIG: begin
          csr_rdata_nxt = '0;
        end
        pcg_pkg::CSR_CLAIM_PRIO: begin
          csr_rdata_nxt[3:0] = pcg_pkg::prio_map(claim_prio_r, i_prio_reverse);
        end
        pcg_pkg::CSR_CUR_PRIO: begin
          csr_rdata_nxt[3:0] = pcg_pkg::prio_map(cur_prio_r, i_prio_reverse);
        end
        pcg_pkg::CSR_HANDLER_PTR: begin
          csr_rdata_nxt = ptr_word;
        end
        default: begin
          csr_rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      csr_rdata_r  <= '0;
      csr_rvalid_r <= 1'b0;
      mm_rvalid_r  <= 1'b0;
    end else begin
      csr_rdata_r  <= csr_rdata_nxt;
      csr_rvalid_r <= i_csr_rd;
      mm_rvalid_r  <= i_mm_rd;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_csr_rdata  = csr_rdata_r;
  assign o_csr_rvalid = csr_rvalid_r;
  assign o_mm_rdata   = {30'h0, gw_rdata};
  assign o_mm_rvalid  = mm_rvalid_r;
  assign o_ext_irq    = irq_r;
  assign o_claim_id   = claim_id_r;
  // Claimed level as software reads it, from a flop
  assign o_claim_prio = claim_view_r;

endmodule // pcg_top

// [inc/pcg_pkg.sv]
package pcg_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int PRIO_W     = 4;
  localparam int ID_W       = 8;
  localparam int MAX_SRC    = 255;
  localparam int CSR_ADDR_W = 12;
  localparam int MM_ADDR_W  = 15;
  localparam int DATA_W     = 32;
  localparam int BASE_W     = 22;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [CSR_ADDR_W-1:0] CSR_CAPTURE_TRIG = 12'hbca;
  localparam logic [CSR_ADDR_W-1:0] CSR_CLAIM_PRIO   = 12'hbcb;
  localparam logic [CSR_ADDR_W-1:0] CSR_CUR_PRIO     = 12'hbcc;
  localparam logic [CSR_ADDR_W-1:0] CSR_HANDLER_PTR  = 12'hfc8;
  localparam logic [MM_ADDR_W-1:0]  MM_GW_CFG_BASE   = 15'h4000;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int GW_POL_BIT   = 0;
  localparam int GW_TYPE_BIT  = 1;
  localparam int GW_CFG_W     = 2;
  localparam int PTR_ID_LSB   = 2;
  localparam int PTR_BASE_LSB = 10;
  localparam logic [PRIO_W-1:0]   PRIO_RST   = 4'h0;
  localparam logic [ID_W-1:0]     ID_RST     = 8'h00;
  localparam logic [GW_CFG_W-1:0] GW_CFG_RST = 2'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    PCG_LEVEL = 1'b0,
    PCG_EDGE  = 1'b1
  } pcg_trig_t;

  // ---------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------
  function automatic logic gw_hit(input logic [MM_ADDR_W-1:0] a);
    return (a[MM_ADDR_W-1:10] == MM_GW_CFG_BASE[MM_ADDR_W-1:10]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [ID_W-1:0] gw_index(input logic [MM_ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic [PRIO_W-1:0] prio_map(input logic [PRIO_W-1:0] v, input logic rev);
    return rev ? ~v : v;
  endfunction

endpackage

// [hw/pcg_gw_cfg_mem.sv]
`timescale 1ns/1ps
module pcg_gw_cfg_mem #(
  parameter int                      NUM_SRC     = 255,
  parameter logic [pcg_pkg::MAX_SRC:0] GW_CFG_MASK = '1
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  input  wire logic [pcg_pkg::MM_ADDR_W-1:0] i_addr,
  input  wire logic [pcg_pkg::GW_CFG_W-1:0]  i_wdata,
  output logic      [pcg_pkg::GW_CFG_W-1:0]  o_rdata,
  output logic      [NUM_SRC:1]             o_type,
  output logic      [NUM_SRC:1]             o_pol
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [pcg_pkg::ID_W-1:0]     idx;
  logic                         hit;
  logic [pcg_pkg::GW_CFG_W-1:0] cfg_r [NUM_SRC:1];
  logic [pcg_pkg::GW_CFG_W-1:0] cfg_nxt [NUM_SRC:1];
  logic [pcg_pkg::GW_CFG_W-1:0] rdata_r;
  logic [pcg_pkg::GW_CFG_W-1:0] rdata_nxt;

  assign idx = pcg_pkg::gw_index(i_addr);
  assign hit = pcg_pkg::gw_hit(i_addr) && (idx != 8'h00) && (int'(idx) <= NUM_SRC);

  // ---------------------------------------------------------------
  // Per-source storage
  // ---------------------------------------------------------------
  for (genvar s = 1; s <= NUM_SRC; s++) begin : g_cfg
    if (GW_CFG_MASK[s]) begin : g_on
      always_comb begin
        cfg_nxt[s] = cfg_r[s];
        if (i_wr && hit && (int'(idx) == s)) begin
          cfg_nxt[s] = i_wdata;
        end
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          cfg_r[s] <= pcg_pkg::GW_CFG_RST;
        end else begin
          cfg_r[s] <= cfg_nxt[s];
        end
      end
    end else begin : g_off
      assign cfg_nxt[s] = pcg_pkg::GW_CFG_RST;
      assign cfg_r[s]   = pcg_pkg::GW_CFG_RST;
    end
    assign o_type[s] = cfg_r[s][pcg_pkg::GW_TYPE_BIT];
    assign o_pol[s]  = cfg_r[s][pcg_pkg::GW_POL_BIT];
  end

  // ---------------------------------------------------------------
  // Registered read
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 2'h0;
    if (i_rd && hit) begin
      rdata_nxt = cfg_r[idx];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_r <= 2'h0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

endmodule // pcg_gw_cfg_mem

// [bench/pcg_core_bfm.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Core side: register access model
// ----------------------------------------
module pcg_core_bfm (
  input  wire logic        i_clk_sys,
  output logic             o_csr_wr,
  output logic             o_csr_rd,
  output logic [11:0]      o_csr_addr,
  output logic [31:0]      o_csr_wdata,
  input  wire logic [31:0] i_csr_rdata,
  input  wire logic        i_csr_rvalid,
  output logic             o_mm_wr,
  output logic             o_mm_rd,
  output logic [14:0]      o_mm_addr,
  output logic [31:0]      o_mm_wdata,
  input  wire logic [31:0] i_mm_rdata,
  input  wire logic        i_mm_rvalid
);
  initial begin
    {o_csr_wr, o_csr_rd, o_mm_wr, o_mm_rd} = 4'h0;
    {o_csr_addr, o_csr_wdata, o_mm_addr, o_mm_wdata} = '0;
  end

  // One access; read data taken with its valid
  task automatic acc(input bit mm, input bit w, input logic [14:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge i_clk_sys);
    {o_csr_wr, o_csr_rd, o_mm_wr, o_mm_rd} = {!mm && w, !mm && !w, mm && w, mm && !w};
    o_csr_addr  = a[11:0];
    o_mm_addr   = a;
    o_csr_wdata = d;
    o_mm_wdata  = d;
    @(negedge i_clk_sys);
    {o_csr_wr, o_csr_rd, o_mm_wr, o_mm_rd} = 4'h0;
    o_csr_addr  = ~o_csr_addr;
    o_mm_addr   = ~o_mm_addr;
    o_csr_wdata = ~o_csr_wdata;
    o_mm_wdata  = ~o_mm_wdata;
    q = mm ? (i_mm_rvalid ? i_mm_rdata : 'x) : (i_csr_rvalid ? i_csr_rdata : 'x);
  endtask

  // Nesting entry: claimed level into current level
  task automatic nest(output logic [31:0] c);
    logic [31:0] q;
    acc(1'b0, 1'b0, 15'h0bcb, 32'h0, c);
    acc(1'b0, 1'b1, 15'h0bcc, c, q);
  endtask
endmodule // pcg_core_bfm

// [bench/pcg_top_sva.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module pcg_top_sva #(
  parameter int NUM_SRC = 255
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rst,
  input wire logic               i_csr_wr,
  input wire logic               i_csr_rd,
  input wire logic [11:0]        i_csr_addr,
  input wire logic [NUM_SRC:1]   i_src_en,
  input wire logic               i_mm_rd,
  input wire logic [31:0]        o_csr_rdata,
  input wire logic               o_csr_rvalid,
  input wire logic [31:0]        o_mm_rdata,
  input wire logic               o_mm_rvalid,
  input wire logic               o_ext_irq,
  input wire logic [7:0]         o_claim_id,
  input wire logic [3:0]         o_claim_prio,
  input wire logic [NUM_SRC:1]   o_gw_pending
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_csr_answer: assert property (i_csr_rd |=> o_csr_rvalid)
    else $error("csr read not answered");
  a_mm_answer: assert property (i_mm_rd |=> o_mm_rvalid)
    else $error("mm read not answered");
  a_trig_reads_zero: assert property (i_csr_rd && i_csr_addr == 12'hbca |=> o_csr_rdata == 32'h0)
    else $error("trigger read not zero");
  a_idle_rdata_zero: assert property (!o_csr_rvalid |-> o_csr_rdata == 32'h0)
    else $error("csr rdata without valid");
  a_cur_upper_zero: assert property (i_csr_rd && i_csr_addr == 12'hbcc |=> o_csr_rdata[31:4] == 28'h0)
    else $error("current level upper bits set");
  a_claim_read: assert property (i_csr_rd && i_csr_addr == 12'hbcb |=>
    o_csr_rdata == {28'h0, $past(o_claim_prio)}) else $error("claimed level read wrong");
  a_claim_id_hold: assert property (!(i_csr_wr && i_csr_addr == 12'hbca) |=> $stable(o_claim_id))
    else $error("claim id moved without trigger");
  a_gw_upper_zero: assert property (o_mm_rvalid |-> o_mm_rdata[31:2] == 30'h0)
    else $error("gateway config upper bits set");
  a_irq_has_cause: assert property (o_ext_irq |-> $past(|(o_gw_pending & i_src_en)))
    else $error("interrupt without enabled request");
endmodule // pcg_top_sva

bind pcg_top pcg_top_sva #(.NUM_SRC(NUM_SRC)) u_sva (.i_clk_sys, .i_rst, .i_csr_wr, .i_csr_rd, .i_csr_addr,
  .i_src_en, .i_mm_rd, .o_csr_rdata, .o_csr_rvalid, .o_mm_rdata, .o_mm_rvalid, .o_ext_irq, .o_claim_id,
  .o_claim_prio, .o_gw_pending);

// [bench/pcg_top_tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// Testbench
// ----------------------------------------
module pcg_top_tb_top;
  localparam int NS = 4;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic [NS:1]     irq, en, clr, gwp, pol;
  logic [NS*4-1:0] prio;
  logic [3:0]      glb, cur_int, exp_ip, cpr;
  logic            rev, ext_irq, csr_wr, csr_rd, csr_rv, mm_wr, mm_rd, mm_rv;
  logic [21:0]     vb;
  logic [7:0]      cid, exp_id;
  logic [11:0]     csr_a;
  logic [14:0]     mm_a;
  logic [31:0]     csr_wd, csr_rdt, mm_wd, mm_rdt, q, c;
  logic [14:0]     bad [3] = '{15'h4000, 15'h4010, 15'h4014};
  int              n_mismatch = 0;
  int              compares = 0;
  int              seed = 32'hc23735ca;

  always #12.5 clk = ~clk;

  pcg_top #(.NUM_SRC(NS), .GW_CFG_MASK(256'he)) dut_u (.i_clk_sys(clk), .i_rst(rst), .i_src_irq(irq),
    .i_src_prio(prio), .i_src_en(en), .i_glb_thresh(glb), .i_prio_reverse(rev), .i_vec_base(vb),
    .i_gw_clr(clr), .i_csr_wr(csr_wr), .i_csr_rd(csr_rd), .i_csr_addr(csr_a), .i_csr_wdata(csr_wd),
    .o_csr_rdata(csr_rdt), .o_csr_rvalid(csr_rv), .i_mm_wr(mm_wr), .i_mm_rd(mm_rd), .i_mm_addr(mm_a),
    .i_mm_wdata(mm_wd), .o_mm_rdata(mm_rdt), .o_mm_rvalid(mm_rv), .o_ext_irq(ext_irq),
    .o_claim_id(cid), .o_claim_prio(cpr), .o_gw_pending(gwp));

  pcg_core_bfm u_core (.i_clk_sys(clk), .o_csr_wr(csr_wr), .o_csr_rd(csr_rd), .o_csr_addr(csr_a),
    .o_csr_wdata(csr_wd), .i_csr_rdata(csr_rdt), .i_csr_rvalid(csr_rv), .o_mm_wr(mm_wr), .o_mm_rd(mm_rd),
    .o_mm_addr(mm_a), .o_mm_wdata(mm_wd), .i_mm_rdata(mm_rdt), .i_mm_rvalid(mm_rv));

  task automatic rd(input bit mm, input logic [14:0] a);
    u_core.acc(mm, 1'b0, a, 32'h0, q);
  endtask

  task automatic wr(input bit mm, input logic [14:0] a, input logic [31:0] d);
    u_core.acc(mm, 1'b1, a, d, q);
  endtask

  // Winner: lowest id with highest internal level
  function automatic void arb();
    logic [3:0] e;
    exp_id = 8'h0;
    exp_ip = 4'h0;
    for (int s = 1; s <= NS; s++) begin
      e = prio[(s-1)*4+:4] ^ {4{rev}};
      if ((irq[s] ^ pol[s]) && en[s] && (exp_id == 8'h0 || e > exp_ip)) begin
        exp_id = 8'(s);
        exp_ip = e;
      end
    end
  endfunction

  function automatic logic irq_exp();
    return exp_id != 8'h0 && exp_ip > cur_int && exp_ip > (glb ^ {4{rev}});
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    {irq, en, clr, prio, glb, rev, pol, cur_int} = '0;
    vb = 22'($random(seed));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd(0, 15'h0bcb); `CHK("claim_rst", 32'h0, q)
    rd(0, 15'h0bcc); `CHK("cur_rst", 32'h0, q)
    rd(1, 15'h4004); `CHK("gw_rst", 32'h0, q)
    wr(0, 15'h0bca, 32'hffffffff);
    rd(0, 15'h0bca); `CHK("trig_read", 32'h0, q)
    rd(0, 15'h0fc8); `CHK("ptr_none", {vb, 10'h0}, q)
    rd(0, 15'h0123); `CHK("csr_unmapped", 32'h0, q)
    foreach (bad[i]) begin
      wr(1, bad[i], 32'h3);
      rd(1, bad[i]); `CHK("gw_absent", 32'h0, q)
    end
    wr(1, 15'h4008, 32'h2);
    rd(1, 15'h4008); `CHK("gw_edge_cfg", 32'h2, q)
    irq[2] = 1'b1;
    @(negedge clk) irq[2] = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("edge_latch", 1'b1, gwp[2])
    clr[2] = 1'b1;
    @(negedge clk) clr[2] = 1'b0;
    `CHK("edge_clear", 1'b0, gwp[2])
    wr(1, 15'h4008, 32'h0);
    irq[2] = 1'b1;
    repeat (3) @(negedge clk);
    wr(1, 15'h4008, 32'h3);
    irq[2] = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("edge_fall", 1'b1, gwp[2])
    clr[2] = 1'b1;
    @(negedge clk) clr[2] = 1'b0;
    `CHK("edge_fall_clear", 1'b0, gwp[2])
    repeat (24) begin
      for (int s = 1; s < NS; s++) begin
        pol[s] = 1'($random(seed));
        wr(1, 15'h4000 + 15'(4 * s), {31'h0, pol[s]});
        rd(1, 15'h4000 + 15'(4 * s)); `CHK("gw_pol", {31'h0, pol[s]}, q)
      end
      {irq, en, clr, glb, rev} = 17'($random(seed));
      prio = 16'($random(seed));
      repeat (5) @(negedge clk);
      arb();
      `CHK("irq", irq_exp(), ext_irq)
      wr(0, 15'h0bca, $random(seed));
      `CHK("claim_id", exp_id, cid)
      `CHK("claim_prio", exp_ip ^ {4{rev}}, cpr)
      rd(0, 15'h0fc8); `CHK("ptr", {vb, exp_id, 2'b00}, q)
      u_core.nest(c);
      `CHK("claimed", {28'h0, exp_ip ^ {4{rev}}}, c)
      cur_int = c[3:0] ^ {4{rev}};
      rd(0, 15'h0bcc); `CHK("cur", c, q)
      repeat (3) @(negedge clk);
      `CHK("irq_nested", irq_exp(), ext_irq)
    end
    end_sim();
  end
endmodule // pcg_top_tb_top
